/* pfm_defs.svh */
// Constants for the port pin function multiplexer.
// Assumes inclusion by bare name from design files.
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH
`define PFM_PINS 8
`define PFM_PIN_TIMER_W_OUT_SELECT 0
`define PFM_PIN_TIMER_FL_OUT_SELECT 1
`define PFM_PIN_TIMER_FH_OUT_SELECT 2
`define PFM_PIN_CAPT 3
`define PFM_PIN_PWM 4
`define PFM_PIN_INT1 5
`define PFM_PIN_INT2 6
`define PFM_PIN_INT3 7
`define PFM_CLK_MODE_EXT 3'h7
`define PFM_FCLK_SEL_EXT 3'h0
`define PFM_BYTE_RESET 8'h00
`endif

/* pfm_pkg.sv */
// Types for the port pin function multiplexer.
// Assumes pfm_defs.svh is on the include path.
`include "pfm_defs.svh"
package pfm_pkg;
    typedef enum logic [4:0] {
        PFM_MODE_ACTIVE = 5'h01,
        PFM_MODE_SUBACTIVE = 5'h02,
        PFM_MODE_HOLD = 5'h04,
        PFM_MODE_STANDBY = 5'h08,
        PFM_MODE_RESET = 5'h10
    } pfm_mode_t;
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] pull_on;
    } pfm_pad_t;
    typedef struct packed {
        pfm_mode_t mode;
        logic [7:0] sync1;
        logic [7:0] sync2;
        pfm_pad_t pad;
    } pfm_state_t;
endpackage

/* pfm_pin_cell.sv */
// One port pin: selects general I/O or alternate function.
// Assumes all inputs are on ref_clk except pad_sync (already synced).
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_cell (
    input wire logic alt_sel,
    input wire logic alt_is_out,
    input wire logic alt_out,
    input wire logic dir_bit,
    input wire logic data_bit,
    input wire logic pullup_bit,
    input wire logic pad_sync,
    output logic oe,
    output logic out,
    output logic pull_on,
    output logic read_bit
);
    always_comb begin
        // Alternate function ignores dir_bit and data latch for oe and out only; pull_on and read_bit still use dir_bit
        oe = alt_sel ? alt_is_out : dir_bit;
        out = alt_sel ? alt_out : data_bit;
        pull_on = ~dir_bit & pullup_bit;
        read_bit = dir_bit ? data_bit : pad_sync;
    end
endmodule
`default_nettype wire

/* pfm_port_mux.sv */
// Pin-function multiplexer and mode-dependent pin states for an 8-bit port.
// Assumes register bits come from ref_clk logic; pad inputs are async.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defs.svh"
module pfm_port_mux (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] pin_function_select_reg,
    input wire logic [7:0] dir_reg,
    input wire logic [7:0] port_data_latch,
    input wire logic [7:0] pullup_reg,
    input wire logic [2:0] timer_f_clk_sel,
    input wire logic [2:0] timer_c_mode,
    input wire logic [2:0] timer_b_mode,
    input wire logic pwm_out,
    input wire logic timer_fh_out,
    input wire logic timer_fl_out,
    input wire logic timer_w_out,
    input wire pfm_pkg::pfm_mode_t op_mode,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup,
    output logic [7:0] port_read,
    output logic ext_int3_in,
    output logic ext_int2_in,
    output logic ext_int1_in,
    output logic timer_f_clock_in,
    output logic timer_c_clock_in,
    output logic timer_b_clock_in,
    output logic capture_in
);
    // Pin map
    // 7: general I/O or interrupt 3, timer F clock in
    // 6: general I/O or interrupt 2, timer C clock in
    // 5: general I/O or interrupt 1, timer B clock in
    // 4: general I/O or PWM out
    // 3: general I/O or capture in
    // 2: general I/O or timer FH out
    // 1: general I/O or timer FL out
    // 0: general I/O or timer W out

    // Registered state, pad synchroniser included
    pfm_pkg::pfm_state_t st;
    pfm_pkg::pfm_state_t next_st;

    // Second synchroniser stage, the only one logic reads
    logic [7:0] sync2;

    // Alternate output drive per pin
    logic [7:0] alt_is_out;
    logic [7:0] alt_out;

    // Pin cell results for functional modes
    logic [7:0] f_oe;
    logic [7:0] f_out;
    logic [7:0] f_pu;

    // Pad sets for functional, standby and off modes
    pfm_pkg::pfm_pad_t func_pad;
    pfm_pkg::pfm_pad_t stby_pad;
    pfm_pkg::pfm_pad_t off_pad;

    // Decoded selects of the input pins
    logic int3_sel;
    logic int2_sel;
    logic int1_sel;
    logic capt_sel;

    // Timer clock source decodes
    logic f_clk_ext;
    logic c_clk_ext;
    logic b_clk_ext;

    // Select and clock source decodes
    always_comb begin
        int3_sel = pin_function_select_reg[`PFM_PIN_INT3];
        int2_sel = pin_function_select_reg[`PFM_PIN_INT2];
        int1_sel = pin_function_select_reg[`PFM_PIN_INT1];
        capt_sel = pin_function_select_reg[`PFM_PIN_CAPT];
        f_clk_ext = timer_f_clk_sel == `PFM_FCLK_SEL_EXT;
        c_clk_ext = timer_c_mode == `PFM_CLK_MODE_EXT;
        b_clk_ext = timer_b_mode == `PFM_CLK_MODE_EXT;
    end

    // Alternate outputs per pin
    always_comb begin
        alt_is_out = `PFM_BYTE_RESET;
        alt_out = `PFM_BYTE_RESET;
        // Input alternates never drive their pins
        alt_is_out[`PFM_PIN_INT3] = 1'b0;
        alt_is_out[`PFM_PIN_INT2] = 1'b0;
        alt_is_out[`PFM_PIN_INT1] = 1'b0;
        alt_is_out[`PFM_PIN_CAPT] = 1'b0;
        // PWM output
        alt_is_out[`PFM_PIN_PWM] = 1'b1;
        alt_out[`PFM_PIN_PWM] = pwm_out;
        // Timer F halves
        alt_is_out[`PFM_PIN_TIMER_FH_OUT_SELECT] = 1'b1;
        alt_out[`PFM_PIN_TIMER_FH_OUT_SELECT] = timer_fh_out;
        alt_is_out[`PFM_PIN_TIMER_FL_OUT_SELECT] = 1'b1;
        alt_out[`PFM_PIN_TIMER_FL_OUT_SELECT] = timer_fl_out;
        // Timer W output
        alt_is_out[`PFM_PIN_TIMER_W_OUT_SELECT] = 1'b1;
        alt_out[`PFM_PIN_TIMER_W_OUT_SELECT] = timer_w_out;
    end

    genvar i;
    generate
        for (i = 0; i < `PFM_PINS; i++) begin : g_pin
            pfm_pin_cell u_cell (
                .alt_sel(pin_function_select_reg[i]),
                .alt_is_out(alt_is_out[i]),
                .alt_out(alt_out[i]),
                .dir_bit(dir_reg[i]),
                .data_bit(port_data_latch[i]),
                .pullup_bit(pullup_reg[i]),
                .pad_sync(sync2[i]),
                .oe(f_oe[i]),
                .out(f_out[i]),
                .pull_on(f_pu[i]),
                .read_bit(port_read[i])
            );
        end
    endgenerate

    // Input routing; interrupt masking is left to software
    always_comb begin
        ext_int3_in = int3_sel
            & sync2[`PFM_PIN_INT3];
        timer_f_clock_in = ext_int3_in
            & f_clk_ext;
        ext_int2_in = int2_sel
            & sync2[`PFM_PIN_INT2];
        timer_c_clock_in = ext_int2_in
            & c_clk_ext;
        ext_int1_in = int1_sel
            & sync2[`PFM_PIN_INT1];
        timer_b_clock_in = ext_int1_in
            & b_clk_ext;
        capture_in = capt_sel
            & sync2[`PFM_PIN_CAPT];
    end

    // Pad sets per mode class
    always_comb begin
        // Functional modes
        func_pad.oe = f_oe;
        func_pad.out = f_out;
        func_pad.pull_on = f_pu;
        // Standby floats, pulled-up pins read high
        stby_pad.oe = `PFM_BYTE_RESET;
        stby_pad.out = `PFM_BYTE_RESET;
        stby_pad.pull_on = f_pu;
        // Reset and unknown codes
        off_pad.oe = `PFM_BYTE_RESET;
        off_pad.out = `PFM_BYTE_RESET;
        off_pad.pull_on = `PFM_BYTE_RESET;
    end

    // Next state: synchroniser and mode-dependent pads
    always_comb begin
        next_st = st;
        next_st.mode = op_mode;
        next_st.sync1 = pad_in;
        next_st.sync2 = st.sync1;
        case (op_mode)
            pfm_pkg::PFM_MODE_ACTIVE,
            pfm_pkg::PFM_MODE_SUBACTIVE: begin
                next_st.pad = func_pad;
            end
            pfm_pkg::PFM_MODE_HOLD: begin
                // Sleep, subsleep and watch keep the pads
                next_st.pad = st.pad;
            end
            pfm_pkg::PFM_MODE_STANDBY: begin
                next_st.pad = stby_pad;
            end
            default: begin
                // Reset mode and unknown codes float
                next_st.pad = off_pad;
            end
        endcase
        if (srst) begin
            next_st.mode = pfm_pkg::PFM_MODE_RESET;
            next_st.sync1 = `PFM_BYTE_RESET;
            next_st.sync2 = `PFM_BYTE_RESET;
            next_st.pad = off_pad;
        end
    end

    // Single state register
    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // Registered pad drive and synchronised levels
    always_comb begin
        pad_oe = st.pad.oe;
        pad_out = st.pad.out;
        pad_pullup = st.pad.pull_on;
        sync2 = st.sync2;
    end
endmodule
`default_nettype wire

/* pfm_chk.sv */
// Checker for pin mux outputs.
// Assumes bind to pfm_port_mux.
`timescale 1ns/1ps
`default_nettype none
module pfm_chk (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] pin_function_select_reg,
    input wire logic [7:0] dir_reg,
    input wire logic [7:0] pullup_reg,
    input wire logic [7:0] port_data_latch,
    input wire logic [2:0] timer_f_clk_sel,
    input wire logic pwm_out,
    input wire pfm_pkg::pfm_mode_t op_mode,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] port_read,
    input wire logic ext_int3_in,
    input wire logic timer_f_clock_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic act = op_mode == pfm_pkg::PFM_MODE_ACTIVE;
    wire logic stby = op_mode == pfm_pkg::PFM_MODE_STANDBY;
    sequence s_pin7_high;
        (pin_function_select_reg[7] && pad_in[7])[*3];
    endsequence
    a_gpio_dir: assert property (
        act && !pin_function_select_reg[4] |=> pad_oe[4] == $past(dir_reg[4]))
        else $error("gpio oe");
    a_pwm_drive: assert property (
        act && pin_function_select_reg[4] |=>
        pad_oe[4] && pad_out[4] == $past(pwm_out)) else $error("pwm");
    a_standby_float: assert property (
        stby |=> pad_oe == 8'h00) else $error("standby oe");
    a_hold_frozen: assert property (
        op_mode == pfm_pkg::PFM_MODE_HOLD |=> $stable(pad_oe) && $stable(pad_out))
        else $error("hold");
    a_pullup_gate: assert property (
        act |=> pad_pullup == ($past(pullup_reg) & ~$past(dir_reg)))
        else $error("pullup");
    a_standby_pull: assert property (
        stby |=> pad_pullup == ($past(pullup_reg) & ~$past(dir_reg)))
        else $error("standby pullup");
    a_read_latch: assert property (
        (port_read & dir_reg) == (port_data_latch & dir_reg)) else $error("read");
    a_int3_route: assert property (
        s_pin7_high |-> ext_int3_in) else $error("int3");
    a_timer_f_clock_in_gate: assert property (
        timer_f_clock_in |-> pin_function_select_reg[7] && timer_f_clk_sel == 3'h0)
        else $error("timer_f_clock_in");
endmodule
`default_nettype wire

/* pfm_port_mux_tb.sv */
// Random bench for the pin mux.
// Assumes pfm_pkg and pfm_chk compiled first.
`timescale 1ns/1ps
`default_nettype none
module pfm_port_mux_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] sel = 8'h00, dir = 8'h00, dat = 8'h00, pul = 8'h00, pad = 8'h00;
    logic [2:0] fs = 3'h1, cm = 3'h0, bm = 3'h0;
    logic [3:0] alt = 4'h0;
    pfm_pkg::pfm_mode_t md = pfm_pkg::PFM_MODE_ACTIVE;
    logic [7:0] oe, po, pu, rd, poe, ppo, ppu, ppad;
    logic [6:0] rt;
    int fails = 0, samples_checked = 0, cyc = 0;
    pfm_port_mux i_pfm_port_mux (.ref_clk(ref_clk), .srst(srst),
        .pin_function_select_reg(sel), .dir_reg(dir), .port_data_latch(dat),
        .pullup_reg(pul), .timer_f_clk_sel(fs), .timer_c_mode(cm),
        .timer_b_mode(bm), .pwm_out(alt[3]), .timer_fh_out(alt[2]),
        .timer_fl_out(alt[1]), .timer_w_out(alt[0]), .op_mode(md),
        .pad_in(pad), .pad_out(po), .pad_oe(oe), .pad_pullup(pu),
        .port_read(rd), .ext_int3_in(rt[6]), .ext_int2_in(rt[5]),
        .ext_int1_in(rt[4]), .timer_f_clock_in(rt[3]),
        .timer_c_clock_in(rt[2]), .timer_b_clock_in(rt[1]),
        .capture_in(rt[0]));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 2000) begin
        fails++;
        complete_run();
    end
    task automatic chk8(input logic [7:0] got, exp, msk);
        samples_checked++;
        if ((got & msk) !== (exp & msk)) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, exp);
        chk8({7'h00, got}, {7'h00, exp}, 8'h01);
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [7:0] e_oe();
        return (sel & 8'h17) | (~sel & dir);
    endfunction
    function automatic logic [7:0] e_out();
        return (sel & {3'h0, alt[3], 1'b0, alt[2:0]}) | (~sel & dat);
    endfunction
    // Routed inputs from the pad levels seen through the synchroniser
    function automatic logic [7:0] e_rt(input logic [7:0] p);
        logic [7:0] h;
        h = sel & p;
        return {1'b0, h[7:5], h[7] & (fs == 3'h0), h[6] & (cm == 3'h7),
            h[5] & (bm == 3'h7), h[3]};
    endfunction
    task automatic step(input logic [7:0] s, d);
        poe = oe;
        ppo = po;
        ppu = pu;
        ppad = pad;
        @(posedge ref_clk);
        sel <= s;
        dir <= d;
        dat <= 8'($urandom);
        pul <= 8'($urandom);
        pad <= 8'($urandom);
        alt <= 4'($urandom);
        md <= pfm_pkg::pfm_mode_t'(5'h01 << ($urandom % 5));
        @(posedge ref_clk);
        #1;
        if (md === pfm_pkg::PFM_MODE_HOLD) begin
            chk8(oe, poe, 8'hff);
            chk8(po, ppo, 8'hff);
            chk8(pu, ppu, 8'hff);
        end else if (md[4:3] != 2'b00) begin
            chk8(oe, 8'h00, 8'hff);
            if (md[3]) chk8(pu, pul & ~dir, 8'hff);
            else chk8(pu, 8'h00, 8'hff);
        end else begin
            chk8(oe, e_oe(), 8'hff);
            chk8(po, e_out(), e_oe());
            chk8(pu, pul & ~dir, 8'hff);
        end
        chk8(rd, dat, dir);
        chk8(rd, ppad, ~dir);
        chk8({1'b0, rt}, e_rt(ppad), 8'h7f);
    endtask
    // Timer clock use, interrupt masked by software
    task automatic route(input int p, input logic [2:0] v, input logic e);
        @(posedge ref_clk);
        sel <= 8'h01 << p; pad <= 8'h01 << p; md <= pfm_pkg::PFM_MODE_ACTIVE;
        fs <= (p == 7) ? v : 3'h1; cm <= (p == 6) ? v : 3'h0;
        bm <= (p == 5) ? v : 3'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk1(rt[p-1], 1'b1);
        chk1(rt[p-4], e);
    endtask
    initial begin
        void'($urandom(78));
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        repeat (200) step(8'($urandom), 8'($urandom));
        step(8'hff, 8'hff);
        step(8'h00, 8'hff);
        route(7, 3'h0, 1'b1);
        route(7, 3'h5, 1'b0);
        route(6, 3'h7, 1'b1);
        route(6, 3'h3, 1'b0);
        route(5, 3'h7, 1'b1);
        route(5, 3'h6, 1'b0);
        @(posedge ref_clk);
        srst <= 1'b1;
        sel <= 8'hff;
        dir <= 8'h00;
        pul <= 8'hff;
        repeat (2) @(posedge ref_clk);
        #1;
        chk8(oe, 8'h00, 8'hff);
        chk8(pu, 8'h00, 8'hff);
        @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        step(8'h0f, 8'h33);
        complete_run();
    end
endmodule
bind pfm_port_mux pfm_chk i_pfm_chk (.ref_clk(ref_clk), .srst(srst),
    .pin_function_select_reg(pin_function_select_reg), .dir_reg(dir_reg),
    .pullup_reg(pullup_reg), .port_data_latch(port_data_latch),
    .timer_f_clk_sel(timer_f_clk_sel), .pwm_out(pwm_out), .op_mode(op_mode),
    .pad_in(pad_in), .pad_oe(pad_oe), .pad_out(pad_out),
    .pad_pullup(pad_pullup), .port_read(port_read),
    .ext_int3_in(ext_int3_in), .timer_f_clock_in(timer_f_clock_in));
`default_nettype wire
